// file: pin_partner.sv
`timescale 1ns/1ps
`default_nettype none

module pin_partner (
	input  wire logic drive_en,
	input  wire logic drive_lvl,
	input  wire logic pin_out,
	input  wire logic pin_oe,
	output logic      pin_in
);
	// wire level of the shared pin; the outside source lets go while the block drives
	always_comb begin
		if (pin_oe) begin
			pin_in = pin_out;
		end else if (drive_en) begin
			pin_in = drive_lvl;
		end else begin
			pin_in = 1'b1; // pull-up holds a released pin high
		end
	end
endmodule

`default_nettype wire

// file: pwm_capture_timer16.sv
// Summary of operation
// - polarity 0 PWM: output low, high at compare match, low at reload.
// - in PWM modes the count restarts at one after every reload.
// - PWM period is reload times prescale system clocks.
// - high fraction is pwm/reload at polarity 1, (reload-pwm)/reload at 0.
// - a non-one start value makes the first period run start to reload.
// - dual PWM turns the shared pin into the complementary output.
// - otherwise the selected shared pin is a timer input, and the counting source in continuous mode.
// - capture copies the count into the PWM registers on the chosen edge.
// - capture mode counts prescaled system clocks, not the pin.
// - capture raises the interrupt, sets the cause flag, keeps counting.
// - capture-mode reload raises the interrupt, clears the cause flag.
// - interrupt fires on both events by default, or one via select field.
// - capture counting starts on the first edge, which raises no interrupt.
// - capture elapsed time is (capture - start) times prescale clocks.
// - high-byte read while enabled latches low byte for the next low read.
// - low-byte read while disabled returns the live count.
// - timer output toggles on every counter reload outside the PWM modes.
`include "timer16_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module pwm_capture_timer16
	import timer16_pkg::*;
#(
	parameter int ADDR_W     = 8,
	parameter int CNT_W      = 16,
	parameter int PRESC_BITS = 3
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              pin_in,
	output logic                   pin_out,
	output logic                   pin_oe,
	output logic                   timer_out,
	output logic                   timer_irq
);
	core_state_t r;
	core_state_t n;
	timer_ctl_if ctl ();

	logic       setup;
	logic       access;
	logic [7:0] off;
	logic       cnt_tick;
	logic       reload_hit;
	logic       cap_evt;
	logic       first_edge;

	initial begin
		if (CNT_W != 16 || ADDR_W < 6 || ADDR_W > 8) begin
			$error("timer supports a 16-bit count and 6 to 8 address bits");
		end
	end

	// decode: true for any mapped register offset
	function automatic logic is_mapped(input logic [7:0] a);
		unique case (a)
			`TMR_OFF_CTRL_A, `TMR_OFF_CTRL_B, `TMR_OFF_CNT_H, `TMR_OFF_CNT_L,
			`TMR_OFF_PWM_H, `TMR_OFF_PWM_L, `TMR_OFF_RLD_H, `TMR_OFF_RLD_L,
			`TMR_OFF_STATUS: is_mapped = 1'b1;
			default:         is_mapped = 1'b0;
		endcase
	endfunction

	// true for modes whose output follows the compare/reload waveform
	function automatic logic is_pwm(input tmr_mode_t m);
		is_pwm = (m == MODE_PWM) || (m == MODE_DUAL);
	endfunction

	timer16_prescaler #(
		.PRESC_BITS(PRESC_BITS)
	) u_presc (
		.pclk    (pclk),
		.presetn (presetn),
		.ctl     (ctl)
	);

	timer16_edge_detect u_edge (
		.pclk    (pclk),
		.presetn (presetn),
		.ctl     (ctl)
	);

	// shared pin is an input only when routed and not driving the complement
	assign ctl.run       = (r.st == ST_RUN);
	assign ctl.presc_sel = r.presc;
	assign ctl.pin_in    = pin_in;
	assign ctl.pin_ok    = r.pin_alt && (r.mode != MODE_DUAL);
	assign ctl.edge_pol  = r.pol;

	assign setup  = psel && !penable;
	assign access = psel && penable;
	assign off    = 8'(paddr);

	// pin counting only in continuous mode; capture always uses the clock
	assign cnt_tick   = (r.mode == MODE_CONT && r.pin_count && ctl.pin_ok)
		? ctl.edge_seen : ctl.tick;
	assign reload_hit = (r.st == ST_RUN) && cnt_tick && (r.cnt == r.rld);
	assign cap_evt    = (r.st == ST_RUN) && (r.mode == MODE_CAP) && ctl.edge_seen;
	assign first_edge = (r.st == ST_ARMED) && ctl.edge_seen;

	always_comb begin
		n = r;
		n.irq = 1'b0;
		n.pready = 1'b1;

		// counting; a start value other than one only shapes the first pass
		if (r.st == ST_RUN && cnt_tick) begin
			if (reload_hit) begin
				n.cnt = `TMR_RESTART;
			end else begin
				n.cnt = 16'(r.cnt + 16'h0001);
			end
		end

		// output waveform: reload returns PWM modes to the polarity level and toggles it otherwise; match flips it
		if (reload_hit) begin
			if (is_pwm(r.mode)) begin
				n.out = r.pol;
			end else begin
				n.out = !r.out;
			end
		end else if (r.st == ST_RUN && cnt_tick && is_pwm(r.mode) && r.cnt == r.pwm) begin
			n.out = !r.pol;
		end

		// capture bookkeeping; a capture in the reload cycle keeps the flag set
		if (reload_hit && r.mode == MODE_CAP) begin
			n.cause = 1'b0;
		end
		if (cap_evt) begin
			n.pwm   = r.cnt;
			n.cause = 1'b1;
		end
		n.irq = (cap_evt && r.irq_sel != IRQ_RELOAD)
			|| (reload_hit && r.irq_sel != IRQ_CAP);

		// the first qualifying edge only starts the count
		if (first_edge) begin
			n.st = ST_RUN;
		end

		// read data and the coherent-read latch are taken in the setup cycle
		if (setup) begin
			n.pslverr = !is_mapped(off);
			n.prdata  = '0;
			unique case (off)
				`TMR_OFF_CTRL_A: begin
					n.prdata[`TMR_A_CAUSE] = r.cause;
					n.prdata[`TMR_A_IRQSEL_LO +: 2] = r.irq_sel;
					n.prdata[`TMR_A_PIN_ALT] = r.pin_alt;
					n.prdata[`TMR_A_PIN_COUNT] = r.pin_count;
				end
				`TMR_OFF_CTRL_B: begin
					n.prdata[`TMR_B_MODE_LO +: 2] = r.mode;
					n.prdata[`TMR_B_PRESC_LO +: 3] = r.presc;
					n.prdata[`TMR_B_POL] = r.pol;
					n.prdata[`TMR_B_EN] = r.en;
				end
				`TMR_OFF_CNT_H: begin
					n.prdata[7:0] = r.cnt[15:8];
					if (!pwrite && r.en) begin
						n.hold = r.cnt[7:0];
					end
				end
				`TMR_OFF_CNT_L:  n.prdata[7:0] = r.en ? r.hold : r.cnt[7:0];
				`TMR_OFF_PWM_H:  n.prdata[7:0] = r.pwm[15:8];
				`TMR_OFF_PWM_L:  n.prdata[7:0] = r.pwm[7:0];
				`TMR_OFF_RLD_H:  n.prdata[7:0] = r.rld[15:8];
				`TMR_OFF_RLD_L:  n.prdata[7:0] = r.rld[7:0];
				`TMR_OFF_STATUS: n.prdata[2:0] = {r.st, r.out};
				default:         n.prdata = '0;
			endcase
		end

		// writes land at the access edge and override the counting above
		if (access && pwrite) begin
			unique case (off)
				`TMR_OFF_CTRL_A: begin
					n.irq_sel   = irq_sel_t'(pwdata[`TMR_A_IRQSEL_LO +: 2]);
					n.pin_alt   = pwdata[`TMR_A_PIN_ALT];
					n.pin_count = pwdata[`TMR_A_PIN_COUNT];
				end
				`TMR_OFF_CTRL_B: begin
					n.mode  = tmr_mode_t'(pwdata[`TMR_B_MODE_LO +: 2]);
					n.presc = pwdata[`TMR_B_PRESC_LO +: 3];
					n.pol   = pwdata[`TMR_B_POL];
					n.en    = pwdata[`TMR_B_EN];
					if (!pwdata[`TMR_B_EN]) begin
						n.st = ST_IDLE;
					end else if (!r.en) begin
						// starting: capture waits for its first edge
						n.st = (tmr_mode_t'(pwdata[`TMR_B_MODE_LO +: 2]) == MODE_CAP)
							? ST_ARMED : ST_RUN;
						n.out = pwdata[`TMR_B_POL];
					end
				end
				`TMR_OFF_CNT_H: n.cnt[15:8] = pwdata[7:0];
				`TMR_OFF_CNT_L: n.cnt[7:0]  = pwdata[7:0];
				`TMR_OFF_PWM_H: if (!cap_evt) n.pwm[15:8] = pwdata[7:0];
				`TMR_OFF_PWM_L: if (!cap_evt) n.pwm[7:0]  = pwdata[7:0];
				`TMR_OFF_RLD_H: n.rld[15:8] = pwdata[7:0];
				`TMR_OFF_RLD_L: n.rld[7:0]  = pwdata[7:0];
				default: ;
			endcase
		end

		// dual mode drives the complement on the shared pin
		n.pin_oe  = n.en && (n.mode == MODE_DUAL);
		n.pin_out = n.pin_oe && !n.out;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r       <= '0;
			r.cnt   <= `TMR_RST_CNT;
			r.pwm   <= `TMR_RST_PWM;
			r.rld   <= `TMR_RST_RLD;
			r.st    <= ST_IDLE;
			r.mode  <= MODE_CONT;
			r.irq_sel <= IRQ_BOTH;
		end else begin
			r <= n;
		end
	end

	assign prdata    = r.prdata;
	assign pready    = r.pready;
	assign pslverr   = r.pslverr;
	assign pin_out   = r.pin_out;
	assign pin_oe    = r.pin_oe;
	assign timer_out = r.out;
	assign timer_irq = r.irq;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic wr_cnt;
	assign wr_cnt = access && pwrite && (off == `TMR_OFF_CNT_H || off == `TMR_OFF_CNT_L);

	a_reload_restart: assert property (reload_hit && !wr_cnt |=> r.cnt == 16'h0001)
		else $error("count did not restart at one after reload");
	a_count_hold: assert property (r.st != ST_RUN && !wr_cnt |=> $stable(r.cnt))
		else $error("count moved while not running");
	a_pwm_match: assert property (r.st == ST_RUN && cnt_tick && is_pwm(r.mode)
		&& r.cnt == r.pwm && r.cnt != r.rld && !(access && pwrite)
		|=> timer_out == !r.pol)
		else $error("output did not flip at compare match");
	a_dual_pin: assert property (r.en && r.mode == MODE_DUAL |-> pin_oe && pin_out == !timer_out)
		else $error("dual mode pin is not the complement");
	a_pin_input: assert property (r.mode != MODE_DUAL |-> !pin_oe)
		else $error("shared pin driven outside dual mode");
	a_capture_copy: assert property (cap_evt |=> r.pwm == $past(r.cnt) && r.cause)
		else $error("capture value or cause flag wrong");
	a_reload_irq: assert property (reload_hit && r.mode == MODE_CAP && !cap_evt
		&& r.irq_sel != IRQ_CAP |=> timer_irq && !r.cause)
		else $error("capture-mode reload lacks irq or flag clear");
	a_irq_select: assert property (cap_evt && !reload_hit && r.irq_sel == IRQ_RELOAD
		|=> !timer_irq)
		else $error("capture irq fired while reload-only");
	a_first_edge: assert property (first_edge |=> !timer_irq && r.st == ST_RUN)
		else $error("first edge misbehaved");
	a_reload_toggle: assert property (reload_hit && r.mode == MODE_CONT
		&& !(access && pwrite) |=> timer_out != $past(timer_out))
		else $error("output did not toggle on reload");
	a_low_hold: assert property (setup && !pwrite && off == `TMR_OFF_CNT_L && r.en
		|=> prdata[7:0] == $past(r.hold))
		else $error("low byte read ignored holding register");

	c_capture: cover property (cap_evt);
	c_pwm_cycle: cover property (reload_hit && r.mode == MODE_PWM);
	c_dual_run: cover property (r.st == ST_RUN && r.mode == MODE_DUAL && pin_oe);
	c_coherent: cover property (setup && off == `TMR_OFF_CNT_H && r.en && !pwrite);

endmodule

`default_nettype wire

// file: pwm_capture_timer16_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "timer16_regs.svh"

module pwm_capture_timer16_bench;
	import timer16_pkg::*;

	typedef struct packed {
		logic        chk;
		logic [32:0] exp;
	} note_t;

	logic        pclk, presetn, psel, penable, pwrite, drive_en, drive_lvl;
	logic [7:0]  paddr, lo, pw;
	logic [31:0] pwdata, prdata, rd, lfsr;
	logic        pready, pslverr, pin_in, pin_out, pin_oe, timer_out, timer_irq, flip;
	logic [15:0] cap_a, cap_b;
	note_t       notes[$];
	note_t       nt;
	int          err_total, samples_checked, irq_cnt, per, hi, lead;
	real         t1;
	logic [7:0]  ra[9] = '{`TMR_OFF_CTRL_A, `TMR_OFF_CTRL_B, `TMR_OFF_CNT_H, `TMR_OFF_CNT_L,
		`TMR_OFF_PWM_H, `TMR_OFF_PWM_L, `TMR_OFF_RLD_H, `TMR_OFF_RLD_L, `TMR_OFF_STATUS};
	logic [7:0]  rv[9] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00};

	pwm_capture_timer16 uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.timer_out(timer_out), .timer_irq(timer_irq));

	pin_partner ext (.drive_en(drive_en), .drive_lvl(drive_lvl), .pin_out(pin_out),
		.pin_oe(pin_oe), .pin_in(pin_in));

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// control B value with the enable bit set
	function automatic logic [7:0] cb(input logic p, input logic [2:0] ps, input tmr_mode_t m);
		return {1'b1, p, ps, 1'b0, m};
	endfunction

	task automatic check(input logic [32:0] got, input logic [32:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		// no local limit: a slave that never answers is left to the watchdog
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rc(input logic [7:0] a, input logic [32:0] e);
		notes.push_back({1'b1, e});
		apb(1'b0, a, 8'h00);
	endtask

	task automatic rx(input logic [7:0] a);
		notes.push_back({1'b0, 33'h0});
		apb(1'b0, a, 8'h00);
	endtask

	task automatic pin(input logic v);
		@(posedge pclk);
		drive_lvl <= v;
	endtask

	// one full period between two reload pulses: length, high cycles, output change
	task automatic measure();
		int n;
		logic o0;
		n = 0;
		@(negedge pclk);
		while (timer_irq !== 1'b1 && n < 3000) begin
			@(negedge pclk);
			n++;
		end
		o0 = timer_out;
		lead = n;
		per = 0;
		hi = 0;
		do begin
			@(negedge pclk);
			per++;
			if (timer_out === 1'b1) hi++;
		end while (timer_irq !== 1'b1 && per < 3000);
		flip = timer_out ^ o0;
	endtask

	// read completions take the oldest note; irq pulses are counted
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			nt = notes.pop_front();
			if (nt.chk) check({pslverr, prdata}, nt.exp);
		end
		if (timer_irq === 1'b1) irq_cnt++;
	end

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// a hang is cut short well past the few thousand cycles the run needs
	initial begin
		repeat (40000) @(posedge pclk);
		err_total++;
		report_and_stop();
	end

	initial begin
		{psel, penable, pwrite, presetn, drive_lvl} = 5'b0;
		drive_en = 1'b1;
		paddr = 8'h00;
		pwdata = 32'h0;
		lfsr = 32'h8c509606;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 9; i++) rc(ra[i], {25'h0, rv[i]});
		rc(8'h24, 33'h100000000);
		// disabled: count holds and the low byte reads live
		wr(`TMR_OFF_CNT_H, 8'h12);
		wr(`TMR_OFF_CNT_L, 8'h34);
		repeat (40) @(posedge pclk);
		rc(`TMR_OFF_CNT_L, 33'h34);
		rc(`TMR_OFF_CNT_H, 33'h12);
		// enabled at divide-by-128: the high read latches the low byte
		lo = lfsr[7:0];
		lfsr = lfsr_next(lfsr);
		wr(`TMR_OFF_CNT_L, lo);
		wr(`TMR_OFF_CTRL_B, cb(1'b0, 3'd7, MODE_CONT));
		rc(`TMR_OFF_CNT_H, 33'h12);
		repeat (600) @(posedge pclk);
		rc(`TMR_OFF_CNT_L, {25'h0, lo});
		wr(`TMR_OFF_CTRL_B, 8'h00);
		// continuous: output toggles on each reload
		wr(`TMR_OFF_CNT_H, 8'h00);
		wr(`TMR_OFF_CNT_L, 8'h01);
		wr(`TMR_OFF_RLD_H, 8'h00);
		wr(`TMR_OFF_RLD_L, 8'h05);
		wr(`TMR_OFF_CTRL_B, cb(1'b0, 3'd0, MODE_CONT));
		measure();
		check(33'(per), 33'd5);
		check({32'h0, flip}, 33'd1);
		wr(`TMR_OFF_CTRL_B, 8'h00);
		// single pwm, both polarities, random compare below reload 6, start 4
		for (int p = 0; p < 2; p++) begin
			pw = 8'd1 + 8'(lfsr % 5);
			lfsr = lfsr_next(lfsr);
			wr(`TMR_OFF_CNT_H, 8'h00);
			wr(`TMR_OFF_CNT_L, 8'h04);
			wr(`TMR_OFF_PWM_H, 8'h00);
			wr(`TMR_OFF_PWM_L, pw);
			wr(`TMR_OFF_RLD_L, 8'h06); // reload stays above every compare value
			wr(`TMR_OFF_CTRL_A, 8'h08);
			wr(`TMR_OFF_CTRL_B, cb(p[0], 3'd1, MODE_PWM)); // enable written last
			measure();
			// first pass 4..6: first tick 3 clocks in, then two more ticks of 2 clocks
			check(33'(lead), 33'd7);
			check(33'(per), 33'd12);
			check(33'(hi), 33'(p ? 2 * pw : 2 * (6 - pw)));
			check({32'h0, flip}, 33'd0);
			check({32'h0, pin_oe}, 33'd0);
			wr(`TMR_OFF_CTRL_B, 8'h00);
		end
		// dual pwm: shared pin becomes the complementary output
		wr(`TMR_OFF_CTRL_B, cb(1'b0, 3'd1, MODE_DUAL));
		measure();
		check(33'(per), 33'd12);
		repeat (8) begin
			@(negedge pclk);
			check({31'h0, pin_oe, pin_out}, {31'h0, 1'b1, ~timer_out});
		end
		wr(`TMR_OFF_CTRL_B, 8'h00);
		// pin as counting source: three rising edges step the count by three
		wr(`TMR_OFF_CNT_L, 8'h01);
		wr(`TMR_OFF_CTRL_A, 8'h18);
		wr(`TMR_OFF_CTRL_B, cb(1'b1, 3'd0, MODE_CONT));
		repeat (3) begin
			pin(1'b1);
			repeat (3) @(posedge pclk);
			pin(1'b0);
			repeat (3) @(posedge pclk);
		end
		wr(`TMR_OFF_CTRL_B, 8'h00);
		rc(`TMR_OFF_CNT_L, 33'h04);
		// capture on rising edges, for each interrupt select but the reserved one
		for (int s = 0; s < 3; s++) begin
			pin(1'b0);
			wr(`TMR_OFF_CNT_L, 8'h01);
			wr(`TMR_OFF_RLD_L, 8'h40);
			wr(`TMR_OFF_CTRL_A, 8'h08 | 8'(s << 1));
			wr(`TMR_OFF_CTRL_B, cb(1'b1, 3'd1, MODE_CAP));
			@(negedge pclk);
			irq_cnt = 0;
			pin(1'b1);
			repeat (10) @(posedge pclk);
			pin(1'b0);
			repeat (10) @(posedge pclk);
			check(33'(irq_cnt), 33'd0);
			pin(1'b1);
			t1 = $realtime;
			repeat (4) @(posedge pclk);
			rx(`TMR_OFF_PWM_H);
			cap_a[15:8] = rd[7:0];
			rx(`TMR_OFF_PWM_L);
			cap_a[7:0] = rd[7:0];
			pin(1'b0);
			while ($realtime < t1 + 725.0) @(posedge pclk);
			pin(1'b1);
			repeat (6) @(posedge pclk);
			check(33'(irq_cnt), (s == 2) ? 33'd0 : 33'd2);
			rc(`TMR_OFF_CTRL_A, 33'(8'h09 | 8'(s << 1)));
			rx(`TMR_OFF_PWM_H);
			cap_b[15:8] = rd[7:0];
			rx(`TMR_OFF_PWM_L);
			cap_b[7:0] = rd[7:0];
			check(33'(cap_b - cap_a), 33'd15);
			@(negedge pclk);
			irq_cnt = 0;
			repeat (150) @(posedge pclk);
			check(33'(irq_cnt), (s == 1) ? 33'd0 : 33'd1);
			rc(`TMR_OFF_CTRL_A, 33'(8'h08 | 8'(s << 1)));
			wr(`TMR_OFF_CTRL_B, 8'h00);
		end
		report_and_stop();
	end
endmodule

`default_nettype wire

// file: timer16_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

module timer16_edge_detect (
	input  wire logic     pclk,
	input  wire logic     presetn,
	timer_ctl_if.edge_det ctl
);
	typedef struct packed {
		logic prev;
		logic seen;
	} edge_st_t;

	edge_st_t r;
	edge_st_t n;

	// polarity 1 picks rising edges, 0 falling; the pin is ignored when not selected
	always_comb begin
		n = r;
		n.prev = ctl.pin_in;
		n.seen = ctl.pin_ok && (ctl.edge_pol ? (ctl.pin_in && !r.prev)
			: (!ctl.pin_in && r.prev));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign ctl.edge_seen = r.seen;

endmodule

`default_nettype wire

// file: timer16_pkg.sv
package timer16_pkg;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ARMED = 2'b01,
		ST_RUN   = 2'b11
	} tmr_state_t;

	typedef enum logic [1:0] {
		MODE_CONT = 2'b00,
		MODE_PWM  = 2'b01,
		MODE_DUAL = 2'b10,
		MODE_CAP  = 2'b11
	} tmr_mode_t;

	typedef enum logic [1:0] {
		IRQ_BOTH   = 2'b00,
		IRQ_CAP    = 2'b01,
		IRQ_RELOAD = 2'b10,
		IRQ_RSVD   = 2'b11
	} irq_sel_t;

	typedef logic [2:0] presc_sel_t;

	typedef struct packed {
		logic        en;
		logic        pol;
		tmr_mode_t   mode;
		presc_sel_t  presc;
		irq_sel_t    irq_sel;
		logic        pin_alt;
		logic        pin_count;
		logic        cause;
		logic [15:0] cnt;
		logic [15:0] pwm;
		logic [15:0] rld;
		logic [7:0]  hold;
		tmr_state_t  st;
		logic        out;
		logic        pin_out;
		logic        pin_oe;
		logic        irq;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} core_state_t;

endpackage

// file: timer16_prescaler.sv
`timescale 1ns/1ps
`default_nettype none

module timer16_prescaler
	import timer16_pkg::*;
#(
	parameter int PRESC_BITS = 3
) (
	input  wire logic   pclk,
	input  wire logic   presetn,
	timer_ctl_if.presc  ctl
);
	localparam int DIV_W = (1 << PRESC_BITS) - 1;

	typedef struct packed {
		logic [DIV_W-1:0] cnt;
		logic             tick;
	} presc_st_t;

	presc_st_t r;
	presc_st_t n;

	initial begin
		if (PRESC_BITS != $bits(presc_sel_t)) begin
			$error("prescaler select width must match the control field");
		end
	end

	// tick once every 2**sel clocks; divider is held cleared while stopped
	always_comb begin
		logic [DIV_W-1:0] last;
		last = DIV_W'((1 << ctl.presc_sel) - 1);
		n = r;
		n.tick = ctl.run && (r.cnt == last);
		if (!ctl.run || r.cnt == last) begin
			n.cnt = '0;
		end else begin
			n.cnt = DIV_W'(r.cnt + 1'b1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign ctl.tick = r.tick;

	a_tick_stop: assert property (@(posedge pclk) disable iff (!presetn)
		!ctl.run |=> !ctl.tick) else $error("tick while stopped");

endmodule

`default_nettype wire

// file: timer16_regs.svh
`ifndef TIMER16_REGS_SVH
`define TIMER16_REGS_SVH

// register byte offsets on the bus
`define TMR_OFF_CTRL_A      8'h00
`define TMR_OFF_CTRL_B      8'h04
`define TMR_OFF_CNT_H       8'h08
`define TMR_OFF_CNT_L       8'h0c
`define TMR_OFF_PWM_H       8'h10
`define TMR_OFF_PWM_L       8'h14
`define TMR_OFF_RLD_H       8'h18
`define TMR_OFF_RLD_L       8'h1c
`define TMR_OFF_STATUS      8'h20

// control A fields
`define TMR_A_CAUSE         0
`define TMR_A_IRQSEL_LO     1
`define TMR_A_PIN_ALT       3
`define TMR_A_PIN_COUNT     4

// control B fields
`define TMR_B_MODE_LO       0
`define TMR_B_PRESC_LO      3
`define TMR_B_POL           6
`define TMR_B_EN            7

// reset and restart values
`define TMR_RST_CNT         16'h0001
`define TMR_RST_PWM         16'h0000
`define TMR_RST_RLD         16'hffff
`define TMR_RESTART         16'h0001

`endif

// file: timer_ctl_if.sv
`timescale 1ns/1ps
`default_nettype none

interface timer_ctl_if;
	import timer16_pkg::*;

	logic       run;
	presc_sel_t presc_sel;
	logic       tick;
	logic       pin_in;
	logic       pin_ok;
	logic       edge_pol;
	logic       edge_seen;

	modport presc (input run, presc_sel, output tick);
	modport edge_det (input pin_in, pin_ok, edge_pol, output edge_seen);
	modport core (output run, presc_sel, pin_in, pin_ok, edge_pol, input tick, edge_seen);
endinterface

`default_nettype wire
